// >>> logic/als_defs.svh
// constants for the light result and range configuration registers
`ifndef ALS_DEFS_SVH
`define ALS_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define ALS_OFS_RESULT 8'h00
`define ALS_OFS_CONFIG 8'h01
`define ALS_RESULT_RESET 16'h0000
`define ALS_CFG_RESET 16'hc810
`define ALS_UNMAPPED_READ 16'h0000

// ****************************************************************
// range and mantissa coding
// ****************************************************************
`define ALS_RN_AUTO 4'hc
`define ALS_EXP_MAX 4'hb
`define ALS_EXP_ZERO 4'h0
`define ALS_MANT_MAX 12'hfff
`define ALS_MANT_HALF 12'h800
`define ALS_MODE_SHUTDOWN 2'h0
`define ALS_MODE_SINGLE 2'h1

// ****************************************************************
// conversion timing
// ****************************************************************
`define ALS_CLK_HZ 10000000
`define ALS_MS_PER_S 1000
`define ALS_CONV_SHORT_MS 100
`define ALS_CONV_LONG_MS 800

// ****************************************************************
// serial bus framing
// ****************************************************************
`define ALS_BITS_PER_BYTE 4'h8
`define ALS_DEV_ADDR_DEFAULT 7'h22

`endif

// >>> logic/als_pkg.sv
// types shared by the light sensor register logic
package als_pkg;

  // ****************************************************************
  // register layouts
  // ****************************************************************
  typedef struct packed {
    logic [3:0] exponent;
    logic [11:0] mantissa;
  } als_result_t;

  typedef struct packed {
    logic [3:0] range_select;
    logic conversion_length_select;
    logic [1:0] mode;
    logic overrange_flag;
    logic conversion_done_flag;
    logic above_limit_flag;
    logic below_limit_flag;
    logic latch;
    logic interrupt_polarity;
    logic exponent_mask;
    logic [1:0] fault_count;
  } als_cfg_t;

  // word write handed from the serial engine to the register bank
  typedef struct packed {
    logic stb;
    logic [7:0] ptr;
    logic [15:0] data;
  } als_reg_wr_t;

  // ****************************************************************
  // state machines
  // ****************************************************************
  typedef enum logic {
    ALS_CONV_IDLE = 1'b0,
    ALS_CONV_RUN = 1'b1
  } als_conv_state_t;

  typedef enum logic [3:0] {
    ALS_BUS_IDLE = 4'h0,
    ALS_BUS_ADDR = 4'h1,
    ALS_BUS_ADDR_ACK = 4'h2,
    ALS_BUS_PTR = 4'h3,
    ALS_BUS_PTR_ACK = 4'h4,
    ALS_BUS_WDATA = 4'h5,
    ALS_BUS_WDATA_ACK = 4'h6,
    ALS_BUS_RDATA = 4'h7,
    ALS_BUS_RACK = 4'h8,
    ALS_BUS_RLOAD = 4'h9
  } als_bus_state_t;

endpackage

// >>> logic/als_i2c_slave.sv
// two-wire serial slave: pointer byte, word writes and word reads, high byte first
`timescale 1ns/1ps
`include "als_defs.svh"

module als_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = `ALS_DEV_ADDR_DEFAULT
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [15:0] rd_word_i,
  output logic [7:0] ptr_o,
  output logic rd_stb_o,
  output als_pkg::als_reg_wr_t wr_o
);

  als_pkg::als_bus_state_t state;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt;
  logic [7:0] rx;
  logic [7:0] hi_byte;
  logic [15:0] tx;
  logic rw;
  logic low_next;

  wire scl_rise = scl_i && !scl_q;
  wire scl_fall = !scl_i && scl_q;
  wire start_cond = scl_i && scl_q && sda_q && !sda_i;
  wire stop_cond = scl_i && scl_q && !sda_q && sda_i;
  wire byte_done = (cnt == `ALS_BITS_PER_BYTE);
  wire addr_hit = (rx[7:1] == DEV_ADDR);

  // ****************************************************************
  // bus engine
  // ****************************************************************
  // open drain: only ever pulls low, so the data level is never driven high
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= als_pkg::ALS_BUS_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt <= 4'h0;
      rx <= 8'h00;
      hi_byte <= 8'h00;
      tx <= 16'h0000;
      rw <= 1'b0;
      low_next <= 1'b0;
      ptr_o <= `ALS_OFS_RESULT;
      rd_stb_o <= 1'b0;
      wr_o <= '0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      rd_stb_o <= 1'b0;
      wr_o.stb <= 1'b0;
      if (start_cond) begin
        state <= als_pkg::ALS_BUS_ADDR;
        cnt <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_cond) begin
        state <= als_pkg::ALS_BUS_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          als_pkg::ALS_BUS_ADDR, als_pkg::ALS_BUS_PTR, als_pkg::ALS_BUS_WDATA: begin
            rx <= {rx[6:0], sda_i};
            cnt <= cnt + 4'h1;
          end
          als_pkg::ALS_BUS_RDATA: cnt <= cnt + 4'h1;
          als_pkg::ALS_BUS_RACK: state <= sda_i ? als_pkg::ALS_BUS_IDLE : als_pkg::ALS_BUS_RLOAD;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          als_pkg::ALS_BUS_ADDR: if (byte_done) begin
            state <= addr_hit ? als_pkg::ALS_BUS_ADDR_ACK : als_pkg::ALS_BUS_IDLE;
            sda_oe_o <= addr_hit;
            rw <= rx[0];
          end
          als_pkg::ALS_BUS_PTR: if (byte_done) begin
            ptr_o <= rx;
            sda_oe_o <= 1'b1;
            state <= als_pkg::ALS_BUS_PTR_ACK;
          end
          als_pkg::ALS_BUS_WDATA: if (byte_done) begin
            sda_oe_o <= 1'b1;
            state <= als_pkg::ALS_BUS_WDATA_ACK;
            low_next <= !low_next;
            if (!low_next) begin
              hi_byte <= rx;
            end else begin
              wr_o <= '{stb: 1'b1, ptr: ptr_o, data: {hi_byte, rx}};
            end
          end
          als_pkg::ALS_BUS_ADDR_ACK: begin
            cnt <= 4'h0;
            if (rw) begin
              tx <= rd_word_i;
              sda_oe_o <= !rd_word_i[15];
              rd_stb_o <= 1'b1;
              low_next <= 1'b1;
              state <= als_pkg::ALS_BUS_RDATA;
            end else begin
              sda_oe_o <= 1'b0;
              low_next <= 1'b0;
              state <= als_pkg::ALS_BUS_PTR;
            end
          end
          als_pkg::ALS_BUS_PTR_ACK, als_pkg::ALS_BUS_WDATA_ACK: begin
            sda_oe_o <= 1'b0;
            cnt <= 4'h0;
            state <= als_pkg::ALS_BUS_WDATA;
          end
          als_pkg::ALS_BUS_RDATA: begin
            tx <= {tx[14:0], 1'b0};
            if (byte_done) begin
              sda_oe_o <= 1'b0;
              state <= als_pkg::ALS_BUS_RACK;
            end else begin
              sda_oe_o <= !tx[14];
            end
          end
          als_pkg::ALS_BUS_RLOAD: begin
            cnt <= 4'h0;
            state <= als_pkg::ALS_BUS_RDATA;
            if (low_next) begin
              sda_oe_o <= !tx[15];
              low_next <= 1'b0;
            end else begin
              tx <= rd_word_i;
              sda_oe_o <= !rd_word_i[15];
              rd_stb_o <= 1'b1;
              low_next <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_msb_first;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_stb_o |-> (sda_oe_o == !$past(rd_word_i[15]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("read word did not start with its top bit");

endmodule

// >>> logic/als_regs.sv
// result and range configuration register bank of the ambient light sensor
`timescale 1ns/1ps
`include "als_defs.svh"

module als_regs #(
  parameter logic [6:0] DEV_ADDR = `ALS_DEV_ADDR_DEFAULT,
  parameter int LIGHT_W = 23,
  parameter int CNT_W = 23,
  parameter int CONV_SHORT_CYC = `ALS_CONV_SHORT_MS * (`ALS_CLK_HZ / `ALS_MS_PER_S),
  parameter int CONV_LONG_CYC = `ALS_CONV_LONG_MS * (`ALS_CLK_HZ / `ALS_MS_PER_S)
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [LIGHT_W-1:0] light_raw_i,
  output logic converting_o
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ****************************************************************
  // serial access
  // ****************************************************************
  als_pkg::als_cfg_t cfg;
  als_pkg::als_result_t result;
  als_pkg::als_reg_wr_t wr;
  logic [7:0] ptr;
  logic rd_stb;
  logic [15:0] rd_word;

  als_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_bus (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .rd_word_i(rd_word),
    .ptr_o(ptr),
    .rd_stb_o(rd_stb),
    .wr_o(wr)
  );

  wire sel_result = (ptr == `ALS_OFS_RESULT);
  wire sel_config = (ptr == `ALS_OFS_CONFIG);
  assign rd_word = sel_result ? result : (sel_config ? cfg : `ALS_UNMAPPED_READ);

  // ****************************************************************
  // quantiser
  // ****************************************************************
  // picks the smallest range whose mantissa still fits, so auto ranging keeps the most resolution
  function automatic logic [16:0] quantise(input logic [LIGHT_W-1:0] raw, input logic [3:0] rn, input logic me);
    logic [LIGHT_W-1:0] shifted;
    logic [3:0] e;
    logic ovf;
    e = rn;
    if (rn == `ALS_RN_AUTO) begin
      e = `ALS_EXP_MAX;
      for (int i = int'(`ALS_EXP_MAX); i >= 0; i--) begin
        if ((raw >> i) <= LIGHT_W'(`ALS_MANT_MAX)) begin
          e = 4'(i);
        end
      end
    end
    shifted = raw >> e;
    ovf = (shifted > LIGHT_W'(`ALS_MANT_MAX));
    if (me && (rn < `ALS_RN_AUTO)) begin
      e = `ALS_EXP_ZERO;
    end
    quantise = {ovf, e, ovf ? `ALS_MANT_MAX : shifted[11:0]};
  endfunction

  wire [16:0] next_sample = quantise(light_raw_i, cfg.range_select, cfg.exponent_mask);

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  als_pkg::als_conv_state_t state;
  logic [CNT_W-1:0] cnt;

  wire cfg_wr = wr.stb && (wr.ptr == `ALS_OFS_CONFIG);
  wire cfg_rd = rd_stb && sel_config;
  als_pkg::als_cfg_t wr_cfg;
  assign wr_cfg = wr.data;
  wire [CNT_W-1:0] conv_last = cfg.conversion_length_select ? CNT_W'(CONV_LONG_CYC - 1) : CNT_W'(CONV_SHORT_CYC - 1);
  wire conv_done = (state == als_pkg::ALS_CONV_RUN) && (cnt == conv_last) && !cfg_wr;
  wire single_done = conv_done && (cfg.mode == `ALS_MODE_SINGLE);
  wire wr_wants_conv = (wr_cfg.mode != `ALS_MODE_SHUTDOWN);
  // completion beats a read clear; a write aborts the conversion so cannot meet a completion
  wire crf_clear = cfg_rd || (cfg_wr && wr_wants_conv);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= als_pkg::ALS_CONV_IDLE;
      cnt <= '0;
      converting_o <= 1'b0;
    end else if (cfg_wr) begin
      state <= wr_wants_conv ? als_pkg::ALS_CONV_RUN : als_pkg::ALS_CONV_IDLE;
      cnt <= '0;
      converting_o <= wr_wants_conv;
    end else if (conv_done) begin
      state <= single_done ? als_pkg::ALS_CONV_IDLE : als_pkg::ALS_CONV_RUN;
      cnt <= '0;
      converting_o <= !single_done;
    end else if (state == als_pkg::ALS_CONV_RUN) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      result <= `ALS_RESULT_RESET;
    end else if (conv_done) begin
      result <= next_sample[15:0];
    end
  end

  // read-only status is never taken from the written word
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= `ALS_CFG_RESET;
    end else begin
      if (cfg_wr) begin
        cfg.range_select <= wr_cfg.range_select;
        cfg.conversion_length_select <= wr_cfg.conversion_length_select;
        cfg.mode <= wr_cfg.mode;
        cfg.latch <= wr_cfg.latch;
        cfg.interrupt_polarity <= wr_cfg.interrupt_polarity;
        cfg.exponent_mask <= wr_cfg.exponent_mask;
        cfg.fault_count <= wr_cfg.fault_count;
      end else if (single_done) begin
        cfg.mode <= `ALS_MODE_SHUTDOWN;
      end
      if (conv_done) begin
        cfg.overrange_flag <= next_sample[16];
        cfg.conversion_done_flag <= 1'b1;
      end else if (crf_clear) begin
        cfg.conversion_done_flag <= 1'b0;
      end
      // no limit comparison is built; both limit flags are held at zero
      cfg.above_limit_flag <= 1'b0;
      cfg.below_limit_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);

  logic first_cycle_done;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      first_cycle_done <= 1'b0;
    end else begin
      first_cycle_done <= 1'b1;
    end
  end

  property p_cfg_reset;
    !first_cycle_done |-> (cfg == `ALS_CFG_RESET) && (cfg.range_select == `ALS_RN_AUTO);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("configuration word left reset wrong");

  property p_result_reset;
    !first_cycle_done |-> (result == `ALS_RESULT_RESET);
  endproperty
  a_result_reset: assert property (p_result_reset) else $error("result word left reset nonzero");

  property p_abort_restart;
    cfg_wr |=> (cnt == '0) && (converting_o == ($past(wr_cfg.mode) != `ALS_MODE_SHUTDOWN));
  endproperty
  a_abort_restart: assert property (p_abort_restart) else $error("configuration write did not restart");

  property p_start_after_write;
    cfg_wr && wr_wants_conv ##1 !cfg_wr |=> (state == als_pkg::ALS_CONV_RUN) && (cnt == CNT_W'(1));
  endproperty
  a_start_after_write: assert property (p_start_after_write) else $error("new conversion did not start");

  property p_single_ends;
    single_done |=> (cfg.mode == `ALS_MODE_SHUTDOWN) && (state == als_pkg::ALS_CONV_IDLE) && !converting_o;
  endproperty
  a_single_ends: assert property (p_single_ends) else $error("single conversion did not shut down");

  property p_mask_zero;
    conv_done && cfg.exponent_mask && (cfg.range_select < `ALS_RN_AUTO) |=> (result.exponent == `ALS_EXP_ZERO);
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("masked exponent not zero");

  property p_manual_range;
    conv_done && !cfg.exponent_mask && (cfg.range_select < `ALS_RN_AUTO) |=>
      (result.exponent == $past(cfg.range_select));
  endproperty
  a_manual_range: assert property (p_manual_range) else $error("exponent differs from programmed range");

  property p_auto_range;
    conv_done && (cfg.range_select == `ALS_RN_AUTO) |=> (result.exponent <= `ALS_EXP_MAX) &&
      ((result.exponent == `ALS_EXP_ZERO) || (result.mantissa >= `ALS_MANT_HALF));
  endproperty
  a_auto_range: assert property (p_auto_range) else $error("automatic range not the tightest fit");

  property p_overrange_saturates;
    conv_done ##1 cfg.overrange_flag |-> (result.mantissa == `ALS_MANT_MAX);
  endproperty
  a_overrange_saturates: assert property (p_overrange_saturates) else $error("overrange without full mantissa");

  property p_status_kept;
    cfg_wr && !conv_done && !crf_clear |=> $stable(cfg.overrange_flag) && $stable(cfg.conversion_done_flag);
  endproperty
  a_status_kept: assert property (p_status_kept) else $error("write changed read-only status");

  property p_result_ro;
    wr.stb && !conv_done |=> $stable(result);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("write changed the result word");

  property p_cfg_fields;
    cfg_wr |=> (cfg.range_select == $past(wr_cfg.range_select)) && (cfg.mode == $past(wr_cfg.mode)) &&
      (cfg.exponent_mask == $past(wr_cfg.exponent_mask)) && (cfg.fault_count == $past(wr_cfg.fault_count));
  endproperty
  a_cfg_fields: assert property (p_cfg_fields) else $error("writable configuration field not taken");

  property p_read_clears;
    cfg_rd && !conv_done |=> !cfg.conversion_done_flag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("configuration read left the done flag set");

  property p_idle_no_update;
    (state == als_pkg::ALS_CONV_IDLE) |=> $stable(result);
  endproperty
  a_idle_no_update: assert property (p_idle_no_update) else $error("result changed while idle");

  property p_converting_state;
    converting_o == (state == als_pkg::ALS_CONV_RUN);
  endproperty
  a_converting_state: assert property (p_converting_state) else $error("converting output disagrees with state");

  property p_count_bound;
    (state == als_pkg::ALS_CONV_RUN) |-> (cnt <= conv_last);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("conversion counter ran past its end");

  property p_single_mode_holds;
    (state == als_pkg::ALS_CONV_RUN) && (cfg.mode == `ALS_MODE_SINGLE) && !conv_done && !cfg_wr |=>
      (state == als_pkg::ALS_CONV_RUN) && (cfg.mode == `ALS_MODE_SINGLE);
  endproperty
  a_single_mode_holds: assert property (p_single_mode_holds) else $error("single mode dropped mid conversion");

  // the reported pair must decode back to the sampled light unless overrange or a manual range with masked exponent
  property p_lsb_weight;
    conv_done && !(cfg.exponent_mask && (cfg.range_select < `ALS_RN_AUTO)) |=>
      cfg.overrange_flag || (($past(light_raw_i) >> result.exponent) == LIGHT_W'(result.mantissa));
  endproperty
  a_lsb_weight: assert property (p_lsb_weight) else $error("mantissa does not match the reported step");

  property p_ovf_flag;
    conv_done && (cfg.range_select <= `ALS_EXP_MAX) |=>
      cfg.overrange_flag == (($past(light_raw_i) >> $past(cfg.range_select)) > LIGHT_W'(`ALS_MANT_MAX));
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overrange flag disagrees with the input");

  c_single_shot: cover property (single_done);
  c_continuous: cover property (conv_done && !single_done);
  c_auto_overrange: cover property (conv_done && (cfg.range_select == `ALS_RN_AUTO) && next_sample[16]);
  c_abort: cover property ((state == als_pkg::ALS_CONV_RUN) && (cnt != '0) && cfg_wr);
  c_flag_read: cover property (cfg_rd && cfg.conversion_done_flag);

endmodule

// >>> testbench/als_host_model.sv
// two-wire bus host model that reaches the light sensor registers
`timescale 1ns/1ps

module als_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h22
) (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // ****************************************************************
  // bit level
  // ****************************************************************
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // sda only moves mid low phase, well away from both scl edges
  task automatic bit_out(input logic b);
    wt(2);
    sda_oe_o = ~b;
    wt(2);
    scl_o = 1'b1;
    wt(4);
    scl_o = 1'b0;
  endtask

  task automatic bit_in(output logic b);
    wt(2);
    sda_oe_o = 1'b0;
    wt(2);
    scl_o = 1'b1;
    wt(2);
    b = sda_i;
    wt(2);
    scl_o = 1'b0;
  endtask

  task automatic start(input logic rep);
    if (rep) begin
      wt(2);
      sda_oe_o = 1'b0;
      wt(2);
      scl_o = 1'b1;
    end
    wt(4);
    sda_oe_o = 1'b1;
    wt(4);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    wt(2);
    sda_oe_o = 1'b1;
    wt(2);
    scl_o = 1'b1;
    wt(4);
    sda_oe_o = 1'b0;
    wt(4);
  endtask

  // ****************************************************************
  // byte and word level
  // ****************************************************************
  task automatic byte_out(input logic [7:0] d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ok = ok & ~a;
  endtask

  task automatic byte_in(output logic [7:0] d, input logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(~ack);
  endtask

  task automatic wr_word(input logic [7:0] ptr, input logic [15:0] data, output logic ok);
    ok = 1'b1;
    start(1'b0);
    byte_out({DEV_ADDR, 1'b0}, ok);
    byte_out(ptr, ok);
    byte_out(data[15:8], ok);
    byte_out(data[7:0], ok);
    stop();
  endtask

  // last byte is refused so the device lets go of sda before stop
  task automatic rd_word(input logic [7:0] ptr, output logic [15:0] data, output logic ok);
    ok = 1'b1;
    start(1'b0);
    byte_out({DEV_ADDR, 1'b0}, ok);
    byte_out(ptr, ok);
    start(1'b1);
    byte_out({DEV_ADDR, 1'b1}, ok);
    byte_in(data[15:8], 1'b1);
    byte_in(data[7:0], 1'b0);
    stop();
  endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the light result and range configuration registers
`timescale 1ns/1ps
`include "als_defs.svh"

module testbench;
  localparam int SHORT_CYC = 20;
  localparam int LONG_CYC = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic host_oe;
  logic dev_oe;
  logic dev_sda;
  logic converting;
  logic [22:0] light_raw = 23'h000000;
  wire sda;
  int n_fail = 0;
  int num_checks = 0;

  // open-drain wire with pull-up
  assign sda = ~((dev_oe & ~dev_sda) | host_oe);

  always #50 clk = ~clk;

  als_regs #(.CONV_SHORT_CYC(SHORT_CYC), .CONV_LONG_CYC(LONG_CYC)) als_regs_i (
    .ref_clk_i(clk),
    .rst_n_i(rst_n),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(dev_sda),
    .sda_oe_o(dev_oe),
    .light_raw_i(light_raw),
    .converting_o(converting)
  );

  als_host_model als_host_model_i (
    .ref_clk_i(clk),
    .sda_i(sda),
    .scl_o(scl),
    .sda_oe_o(host_oe)
  );

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    als_host_model_i.rd_word(ptr, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(d, exp);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
    logic ok;
    als_host_model_i.wr_word(ptr, data, ok);
    chk({15'h0000, ok}, 16'h0001);
  endtask

  // waits are bounded so a stuck conversion cannot hang the run
  task automatic conv(input logic [15:0] cfg, input logic [22:0] raw);
    light_raw = raw;
    wr(`ALS_OFS_CONFIG, cfg);
    for (int i = 0; i < 100 && converting !== 1'b0; i++) @(negedge clk);
    chk({15'h0000, converting}, 16'h0000);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #5_000_000;
    n_fail++;
    end_sim();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    rd(`ALS_OFS_CONFIG, `ALS_CFG_RESET);
    rd(`ALS_OFS_RESULT, `ALS_RESULT_RESET);
    rd(8'h05, `ALS_UNMAPPED_READ);
    $display("test reset_values done");
    // status bits written as ones must not stick
    conv(16'h33fb, 23'h0022b0);
    rd(`ALS_OFS_CONFIG, 16'h309b);
    rd(`ALS_OFS_CONFIG, 16'h301b);
    rd(`ALS_OFS_RESULT, 16'h3456);
    $display("test manual_single done");
    conv(16'h0200, 23'h001000);
    rd(`ALS_OFS_RESULT, 16'h0fff);
    rd(`ALS_OFS_CONFIG, 16'h0180);
    conv(16'h5204, 23'h002460);
    rd(`ALS_OFS_RESULT, 16'h0123);
    // mask must not hide the exponent while ranging automatically
    conv(16'hc204, 23'h044d00);
    rd(`ALS_OFS_RESULT, 16'h789a);
    $display("test saturate_mask_auto done");
    // only codes 0 to 11 are programmed by hand
    for (int e = 0; e < 12; e++) begin
      conv({e[3:0], 12'h200}, 23'h000fff << e);
      rd(`ALS_OFS_RESULT, {e[3:0], 12'hfff});
    end
    // 5242.88 lux reads back differently in each upper range
    for (int e = 8; e < 12; e++) begin
      conv({e[3:0], 12'h200}, 23'h080000);
      rd(`ALS_OFS_RESULT, {e[3:0], 12'h800 >> (e - 8)});
    end
    $display("test range_table done");
    light_raw = 23'h0000ab;
    wr(`ALS_OFS_CONFIG, 16'h0c00);
    chk({15'h0000, converting}, 16'h0001);
    rd(`ALS_OFS_RESULT, 16'h00ab);
    wr(`ALS_OFS_CONFIG, 16'h0600);
    chk({15'h0000, converting}, 16'h0001);
    light_raw = 23'h0000cd;
    wr(`ALS_OFS_CONFIG, 16'h0000);
    chk({15'h0000, converting}, 16'h0000);
    light_raw = 23'h000111;
    repeat (LONG_CYC + 10) @(negedge clk);
    rd(`ALS_OFS_RESULT, 16'h00cd);
    // a shutdown write keeps the done flag
    rd(`ALS_OFS_CONFIG, 16'h0080);
    wr(`ALS_OFS_RESULT, 16'hffff);
    rd(`ALS_OFS_RESULT, 16'h00cd);
    $display("test continuous_abort done");
    end_sim();
  end
endmodule
